// ==== fpc_regs.svh ====
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// ----------------------------------------
// Timing and programmable lamp port
// ----------------------------------------
`define FPC_CLK_NS      20
`define FPC_DEB_NS      1000000
`define FPC_DEB_CYC     (`FPC_DEB_NS / `FPC_CLK_NS)
`define FPC_ACC_NS      500
`define FPC_ACC_CYC     ((`FPC_ACC_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_PROG_PORT   8'hff

// ----------------------------------------
// Register map
// ----------------------------------------
`define FPC_OFF_STATUS  32'h0000_0000
`define FPC_OFF_ADDR    32'h0000_0004
`define FPC_OFF_CTRL    32'h0000_0008
`define FPC_CTRL_WAIT   0
`define FPC_CTRL_SRCH   1
`define FPC_CTRL_SENSE  2
`define FPC_CTRL_RST    3'h0
`define FPC_RESP_OKAY   2'h0
`define FPC_RESP_SLVERR 2'h2
`endif

// ==== fpc_pkg.sv ====
package fpc_pkg;
  typedef struct packed {
    logic waiting;
    logic halt_ack;
    logic hold_ack;
    logic int_dis;
    logic fetch;
    logic int_cycle;
    logic stack;
    logic mem_rd;
    logic mem_wr;
    logic io_in;
    logic io_out;
    logic sync;
  } fpc_cpu_t;

  typedef struct packed {
    logic load;
    logic store_key;
    logic step_up;
    logic address_step_down_key;
    logic intr;
    logic reset_key;
    logic pass_load;
    logic single_step;
  } fpc_keys_t;

  typedef struct packed {
    logic run;
    logic waiting;
    logic halt;
    logic hold;
    logic search_done_lamp;
    logic access_req;
    logic int_req;
    logic int_dis;
  } fpc_status_t;

  typedef struct packed {
    logic fetch;
    logic mem;
    logic io;
    logic direct_access_cycle_lamp;
    logic rd_in;
    logic wr_out;
    logic intr;
    logic stack;
  } fpc_cycle_t;

  typedef enum logic [2:0] {ACC_IDLE, ACC_MEM_RD, ACC_MEM_WR, ACC_IO_RD, ACC_IO_WR} fpc_acc_t;
endpackage : fpc_pkg

// ==== fpc_debounce.sv ====
`timescale 1ns/1ns
module fpc_debounce #(
  parameter int unsigned CYC = 50000
) (
  input  wire logic mclk_i,  // System clock
  input  wire logic srst_i,  // Sync reset
  input  wire logic key_i,   // Raw momentary key
  output logic      press_o  // One-clock press pulse
);
  logic [16:0] cnt_ff;
  logic        stable_ff;

  // Key must hold a new level for CYC clocks before it counts
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_ff    <= 17'h0;
      stable_ff <= 1'b0;
      press_o   <= 1'b0;
    end else begin
      press_o <= 1'b0;
      if (key_i == stable_ff) begin
        cnt_ff <= 17'h0;
      end else if (cnt_ff >= 17'(CYC - 1)) begin
        cnt_ff    <= 17'h0;
        stable_ff <= key_i;
        press_o   <= key_i;
      end else begin
        cnt_ff <= cnt_ff + 17'h1;
      end
    end
  end

  property p_one_pulse;
    @(posedge mclk_i) disable iff (srst_i) press_o |=> !press_o;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("press pulse too long");
endmodule : fpc_debounce

// ==== fpc_console.sv ====
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`include "fpc_regs.svh"
module fpc_console #(
  parameter int unsigned DEBOUNCE_CYC = `FPC_DEB_CYC
) (
  input  wire logic              mclk_i,         // System clock
  input  wire logic              srst_i,         // Sync reset
  input  wire logic [15:0]       panel_sw_i,     // Address/data switches
  input  wire fpc_pkg::fpc_keys_t keys_i,        // Momentary keys, raw
  input  wire logic              mem_acc_sw_i,   // Memory access toggle
  input  wire logic              io_acc_sw_i,    // I/O access toggle
  input  wire logic              io_in_sw_i,     // Console I/O is input
  input  wire logic              wait_sw_i,      // Wait toggle
  input  wire logic              srch_wait_sw_i, // Search-wait toggle
  input  wire logic              sense_sw_i,     // Sense toggle
  input  wire fpc_pkg::fpc_cpu_t cpu_i,          // Processor status
  input  wire logic [15:0]       cpu_addr_i,     // Processor address bus
  input  wire logic [7:0]        cpu_data_i,     // Processor data bus
  input  wire logic [7:0]        bus_rdata_i,    // Read data to console
  output logic                   hold_req_o,     // Hold request
  output logic                   int_req_o,      // Interrupt request
  output logic                   wait_req_o,     // Force wait
  output logic [15:0]            bus_addr_o,     // Console address
  output logic [7:0]             bus_data_o,     // Console data
  output logic                   bus_data_oe_o,  // Console drives data
  output logic                   bus_mem_rd_o,   // Console memory read
  output logic                   bus_mem_wr_o,   // Console memory write
  output logic                   bus_io_rd_o,    // Console port input
  output logic                   bus_io_wr_o,    // Console port output
  output fpc_pkg::fpc_status_t   st_lamp_o,      // Status lamps
  output fpc_pkg::fpc_cycle_t    cyc_lamp_o,     // Cycle lamps
  output logic [15:0]            addr_lamp_o,    // Address lamps
  output logic [7:0]             data_lamp_o,    // Data lamps
  output logic [7:0]             prog_lamp_o,    // Programmable lamps
  input  wire logic [31:0]       s_axi_awaddr,   // AXI write address
  input  wire logic              s_axi_awvalid,  // AXI
  output logic                   s_axi_awready,  // AXI
  input  wire logic [31:0]       s_axi_wdata,    // AXI write data
  input  wire logic [3:0]        s_axi_wstrb,    // AXI
  input  wire logic              s_axi_wvalid,   // AXI
  output logic                   s_axi_wready,   // AXI
  output logic [1:0]             s_axi_bresp,    // AXI
  output logic                   s_axi_bvalid,   // AXI
  input  wire logic              s_axi_bready,   // AXI
  input  wire logic [31:0]       s_axi_araddr,   // AXI read address
  input  wire logic              s_axi_arvalid,  // AXI
  output logic                   s_axi_arready,  // AXI
  output logic [31:0]            s_axi_rdata,    // AXI read data
  output logic [1:0]             s_axi_rresp,    // AXI
  output logic                   s_axi_rvalid,   // AXI
  input  wire logic              s_axi_rready    // AXI
);
  localparam logic [4:0] ACC_LAST = 5'(`FPC_ACC_CYC - 1);

  logic [7:0]          key_raw;
  logic [7:0]          key_p;
  fpc_pkg::fpc_keys_t  kp;
  fpc_pkg::fpc_acc_t   acc_ff;
  logic [4:0]          acc_cnt_ff;
  logic [15:0]         addr_ff;
  logic [7:0]          pass_ff;
  logic                armed_ff;
  logic                done_ff;
  logic                step_ff;
  logic                inject_ff;
  logic [7:0]          con_data_ff;
  logic [2:0]          ctrl_ff;
  logic [31:0]         awaddr_ff;
  logic [31:0]         wdata_ff;
  logic [3:0]          wstrb_ff;
  logic                mem_gnt;
  logic                io_gnt;
  logic                match;
  logic                wait_hold;
  logic                sense_on;
  logic                con_rd;
  logic                con_wr;

  // ----------------------------------------
  // Key conditioning
  // ----------------------------------------
  assign key_raw = keys_i;
  for (genvar i = 0; i < 8; i++) begin : g_key
    fpc_debounce #(.CYC(DEBOUNCE_CYC)) u_deb (
      .mclk_i  (mclk_i),
      .srst_i  (srst_i),
      .key_i   (key_raw[i]),
      .press_o (key_p[i])
    );
  end
  assign kp = fpc_pkg::fpc_keys_t'(key_p);

  assign mem_gnt   = cpu_i.hold_ack & mem_acc_sw_i;
  assign io_gnt    = cpu_i.hold_ack & io_acc_sw_i & ~mem_acc_sw_i;
  assign match     = cpu_i.fetch & cpu_i.sync & (cpu_addr_i == addr_ff);
  assign sense_on  = sense_sw_i | ctrl_ff[`FPC_CTRL_SENSE];
  assign wait_hold = wait_sw_i | ctrl_ff[`FPC_CTRL_WAIT] |
                     ((srch_wait_sw_i | ctrl_ff[`FPC_CTRL_SRCH]) & done_ff);
  assign con_rd    = (acc_ff == fpc_pkg::ACC_MEM_RD) | (acc_ff == fpc_pkg::ACC_IO_RD);
  assign con_wr    = (acc_ff == fpc_pkg::ACC_MEM_WR) | (acc_ff == fpc_pkg::ACC_IO_WR);

  // ----------------------------------------
  // Console access sequencer
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      acc_ff     <= fpc_pkg::ACC_IDLE;
      acc_cnt_ff <= 5'h0;
    end else begin
      case (acc_ff)
        fpc_pkg::ACC_IDLE: begin
          acc_cnt_ff <= ACC_LAST;
          if (mem_gnt) begin
            acc_ff <= fpc_pkg::ACC_MEM_RD;
          end else if (io_gnt && kp.store_key) begin
            acc_ff <= io_in_sw_i ? fpc_pkg::ACC_IO_RD : fpc_pkg::ACC_IO_WR;
          end
        end
        fpc_pkg::ACC_MEM_RD: begin
          acc_cnt_ff <= ACC_LAST;
          if (!mem_gnt) begin
            acc_ff <= fpc_pkg::ACC_IDLE;
          end else if (kp.store_key) begin
            acc_ff <= fpc_pkg::ACC_MEM_WR;
          end
        end
        fpc_pkg::ACC_MEM_WR, fpc_pkg::ACC_IO_RD, fpc_pkg::ACC_IO_WR: begin
          acc_cnt_ff <= acc_cnt_ff - 5'h1;
          if (acc_cnt_ff == 5'h0) begin
            acc_ff <= (acc_ff == fpc_pkg::ACC_MEM_WR) ? fpc_pkg::ACC_MEM_RD
                                                     : fpc_pkg::ACC_IDLE;
          end
        end
        default: acc_ff <= fpc_pkg::ACC_IDLE;
      endcase
    end
  end

  // Read data is caught while the strobe is up, so lamps keep it afterwards
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      con_data_ff <= 8'h00;
    end else if (con_rd && bus_mem_rd_o | bus_io_rd_o) begin
      con_data_ff <= bus_rdata_i;
    end
  end

  // ----------------------------------------
  // Address register and step keys
  // ----------------------------------------
  // Load stays open outside hold: search-wait needs the address too
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      addr_ff <= 16'h0000;
    end else if (kp.load) begin
      addr_ff <= panel_sw_i;
    end else if (kp.step_up && mem_gnt) begin
      addr_ff <= addr_ff + 16'h0001;
    end else if (kp.address_step_down_key && mem_gnt) begin
      addr_ff <= addr_ff - 16'h0001;
    end
  end

  // ----------------------------------------
  // Search-wait pass counter
  // ----------------------------------------
  // A loaded zero wraps, giving 256 passes
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pass_ff  <= 8'h00;
      armed_ff <= 1'b0;
      done_ff  <= 1'b0;
    end else if (kp.pass_load) begin
      pass_ff  <= panel_sw_i[7:0];
      armed_ff <= 1'b1;
      done_ff  <= 1'b0;
    end else if (match && armed_ff) begin
      pass_ff <= pass_ff - 8'h01;
      if (pass_ff == 8'h01) begin
        armed_ff <= 1'b0;
        done_ff  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Wait and single cycle
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      step_ff <= 1'b0;
    end else if (kp.single_step && wait_hold) begin
      step_ff <= 1'b1;
    end else if (cpu_i.sync) begin
      step_ff <= 1'b0;  // Next cycle start ends the step
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wait_req_o <= 1'b0;
      hold_req_o <= 1'b0;
    end else begin
      wait_req_o <= wait_hold & ~step_ff;
      hold_req_o <= mem_acc_sw_i | io_acc_sw_i;
    end
  end

  // ----------------------------------------
  // Console interrupt
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      int_req_o <= 1'b0;
      inject_ff <= 1'b0;
    end else begin
      if (kp.intr || kp.reset_key) begin
        int_req_o <= 1'b1;
      end else if (cpu_i.int_cycle) begin
        int_req_o <= 1'b0;
      end
      inject_ff <= cpu_i.int_cycle & (int_req_o | inject_ff);
    end
  end

  // ----------------------------------------
  // Bus drive
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      bus_addr_o    <= 16'h0000;
      bus_data_o    <= 8'h00;
      bus_data_oe_o <= 1'b0;
      bus_mem_rd_o  <= 1'b0;
      bus_mem_wr_o  <= 1'b0;
      bus_io_rd_o   <= 1'b0;
      bus_io_wr_o   <= 1'b0;
    end else begin
      bus_addr_o   <= mem_gnt ? addr_ff : {8'h00, panel_sw_i[15:8]};
      bus_mem_rd_o <= acc_ff == fpc_pkg::ACC_MEM_RD;
      bus_mem_wr_o <= acc_ff == fpc_pkg::ACC_MEM_WR;
      bus_io_rd_o  <= acc_ff == fpc_pkg::ACC_IO_RD;
      bus_io_wr_o  <= acc_ff == fpc_pkg::ACC_IO_WR;
      if (cpu_i.int_cycle && (int_req_o || inject_ff)) begin
        bus_data_o    <= panel_sw_i[7:0];
        bus_data_oe_o <= 1'b1;
      end else if (sense_on && cpu_i.io_in && !cpu_i.hold_ack) begin
        bus_data_o    <= panel_sw_i[15:8];
        bus_data_oe_o <= 1'b1;
      end else begin
        bus_data_o    <= panel_sw_i[7:0];
        bus_data_oe_o <= con_wr;
      end
    end
  end

  // ----------------------------------------
  // Lamps
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_lamp_o   <= '0;
      cyc_lamp_o  <= '0;
      addr_lamp_o <= 16'h0000;
      data_lamp_o <= 8'h00;
      prog_lamp_o <= 8'h00;
    end else begin
      st_lamp_o.run              <= ~cpu_i.waiting & ~cpu_i.halt_ack;
      st_lamp_o.waiting          <= cpu_i.waiting;
      st_lamp_o.halt             <= cpu_i.halt_ack;
      st_lamp_o.hold             <= cpu_i.hold_ack;
      st_lamp_o.int_dis          <= cpu_i.int_dis;
      st_lamp_o.search_done_lamp <= done_ff;
      st_lamp_o.access_req       <= mem_acc_sw_i | io_acc_sw_i;
      st_lamp_o.int_req          <= int_req_o;
      cyc_lamp_o.fetch <= cpu_i.fetch;
      cyc_lamp_o.intr  <= cpu_i.int_cycle;
      cyc_lamp_o.stack <= cpu_i.stack;
      cyc_lamp_o.mem   <= cpu_i.mem_rd | cpu_i.mem_wr | mem_gnt;
      cyc_lamp_o.io    <= cpu_i.io_in | cpu_i.io_out | io_gnt;
      cyc_lamp_o.direct_access_cycle_lamp <= mem_gnt | io_gnt;
      cyc_lamp_o.rd_in  <= cpu_i.mem_rd | cpu_i.io_in | con_rd;
      cyc_lamp_o.wr_out <= cpu_i.mem_wr | cpu_i.io_out | con_wr;
      addr_lamp_o <= cpu_i.hold_ack ? bus_addr_o : cpu_addr_i;
      data_lamp_o <= cpu_i.hold_ack ? con_data_ff : cpu_data_i;
      if (cpu_i.io_out && cpu_addr_i[7:0] == `FPC_PROG_PORT) begin
        prog_lamp_o <= cpu_data_i;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FPC_RESP_OKAY;
      awaddr_ff     <= 32'h0000_0000;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      ctrl_ff       <= `FPC_CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `FPC_RESP_OKAY;
        if (awaddr_ff == `FPC_OFF_CTRL) begin
          if (wstrb_ff[0]) begin
            ctrl_ff <= wdata_ff[2:0];
          end
        end else if (awaddr_ff != `FPC_OFF_STATUS && awaddr_ff != `FPC_OFF_ADDR) begin
          s_axi_bresp <= `FPC_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `FPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `FPC_RESP_OKAY;
      case (s_axi_araddr)
        `FPC_OFF_STATUS: s_axi_rdata <= {16'h0000, cyc_lamp_o, st_lamp_o};
        `FPC_OFF_ADDR:   s_axi_rdata <= {8'h00, pass_ff, addr_ff};
        `FPC_OFF_CTRL:   s_axi_rdata <= {29'h0000_0000, ctrl_ff};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `FPC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  property p_run;
    !cpu_i.waiting && !cpu_i.halt_ack |=> st_lamp_o.run;
  endproperty
  a_run: assert property (p_run) else $error("run lamp dark");

  property p_hold_lamp;
    cpu_i.hold_ack |=> st_lamp_o.hold && cyc_lamp_o.direct_access_cycle_lamp == $past(mem_gnt | io_gnt);
  endproperty
  a_hold_lamp: assert property (p_hold_lamp) else $error("hold lamps wrong");

  property p_int_set;
    kp.intr |=> int_req_o ##1 st_lamp_o.int_req;
  endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt request lost");

  property p_int_clr;
    cpu_i.int_cycle && !kp.intr && !kp.reset_key |=> !int_req_o;
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("interrupt not cleared");

  property p_mem_wr;
    acc_ff == fpc_pkg::ACC_MEM_RD && mem_gnt && kp.store_key |=> ##1 bus_mem_wr_o [*8];
  endproperty
  a_mem_wr: assert property (p_mem_wr) else $error("store write too short");

  property p_no_grant;
    acc_ff == fpc_pkg::ACC_IDLE && !cpu_i.hold_ack |=> acc_ff == fpc_pkg::ACC_IDLE;
  endproperty
  a_no_grant: assert property (p_no_grant) else $error("access without grant");

  property p_step_up;
    kp.step_up && mem_gnt && !kp.load |=> addr_ff == $past(addr_ff) + 16'h0001;
  endproperty
  a_step_up: assert property (p_step_up) else $error("step up failed");

  property p_pass_load;
    kp.pass_load |=> pass_ff == $past(panel_sw_i[7:0]) && !done_ff ##1 !st_lamp_o.search_done_lamp;
  endproperty
  a_pass_load: assert property (p_pass_load) else $error("pass load failed");

  property p_dec;
    match && armed_ff && !kp.pass_load |=> pass_ff == $past(pass_ff) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("pass count not decremented");

  property p_wait;
    wait_sw_i && !step_ff && !(kp.single_step) |=> wait_req_o;
  endproperty
  a_wait: assert property (p_wait) else $error("wait not forced");

  property p_sense;
    sense_sw_i && cpu_i.io_in && !cpu_i.int_cycle && !cpu_i.hold_ack
      |=> bus_data_oe_o && bus_data_o == $past(panel_sw_i[15:8]);
  endproperty
  a_sense: assert property (p_sense) else $error("sense data missing");

  c_store: cover property (acc_ff == fpc_pkg::ACC_MEM_WR ##1 acc_ff == fpc_pkg::ACC_MEM_RD);
  c_done:  cover property (armed_ff ##1 done_ff);
  c_step:  cover property (step_ff ##1 !step_ff ##1 wait_req_o);
  c_inject: cover property (inject_ff && bus_data_oe_o);
endmodule : fpc_console

// ==== fpc_cpu_model.sv ====
`timescale 1ns/1ns
module fpc_cpu_model (
  input  wire logic         mclk_i,     // System clock
  input  wire logic         srst_i,     // Sync reset
  input  wire logic         hold_req_i, // Hold request
  input  wire logic         int_req_i,  // Interrupt request
  input  wire logic         wait_req_i, // Forced wait
  output fpc_pkg::fpc_cpu_t cpu_o       // Processor status
);
  logic [1:0] icnt_ff;

  // Grants and acks lag one cycle, as a real core would
  // Interrupt cycle spans several clocks, like a machine cycle
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cpu_o   <= '0;
      icnt_ff <= 2'h0;
    end else begin
      cpu_o.hold_ack  <= hold_req_i;
      cpu_o.waiting   <= wait_req_i;
      if (int_req_i && !cpu_o.int_dis) begin
        cpu_o.int_cycle <= 1'b1;
        icnt_ff         <= 2'h3;
      end else if (icnt_ff != 2'h0) begin
        icnt_ff <= icnt_ff - 2'h1;
      end else begin
        cpu_o.int_cycle <= 1'b0;
      end
      if (int_req_i) begin
        cpu_o.int_dis <= 1'b1;
      end
    end
  end
endmodule : fpc_cpu_model

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  logic mclk_i, srst_i, mem_acc_sw_i, io_acc_sw_i, io_in_sw_i, wait_sw_i, srch_wait_sw_i;
  logic sense_sw_i, hold_req_o, int_req_o, wait_req_o, bus_data_oe_o, bus_mem_rd_o, da;
  logic bus_mem_wr_o, bus_io_rd_o, bus_io_wr_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  cpu_data_i, bus_rdata_i, bus_data_o, data_lamp_o, prog_lamp_o, wd, id;
  logic [15:0] panel_sw_i, cpu_addr_i, bus_addr_o, addr_lamp_o, wa;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  fpc_pkg::fpc_keys_t   keys_i;
  fpc_pkg::fpc_cpu_t    mc, cx, cpu_i;
  fpc_pkg::fpc_status_t st_lamp_o;
  fpc_pkg::fpc_cycle_t  cyc_lamp_o;
  int mismatches = 0, tests_run = 0, cyc = 0, nw = 0;
  // Bench-driven cycle types are merged over the model's handshakes
  assign cpu_i = mc | cx;
  fpc_console #(.DEBOUNCE_CYC(4)) uut (.*);
  fpc_cpu_model cpu (.mclk_i, .srst_i, .hold_req_i(hold_req_o), .int_req_i(int_req_o),
                     .wait_req_i(wait_req_o), .cpu_o(mc));
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    tick(1);
    while (s_axi_awvalid || s_axi_wvalid || s_axi_bready) begin
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        rr = s_axi_bresp;
      end
      tick(1);
    end
  endtask : axw
  task automatic axr(input logic [31:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    tick(1);
    while (s_axi_arvalid || s_axi_rready) begin
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
      end
      tick(1);
    end
  endtask : axr
  // Long tail lets any 25-cycle access strobe finish
  task automatic press(input int k, input logic [15:0] sw);
    panel_sw_i <= sw;
    keys_i[k]  <= 1'b1;
    tick(8);
    keys_i[k]  <= 1'b0;
    tick(40);
  endtask : press
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge mclk_i) begin
    nw <= nw + int'(bus_mem_wr_o);
    if (bus_mem_wr_o || bus_io_wr_o) begin
      wa <= bus_addr_o;
      wd <= bus_data_o;
      da <= cyc_lamp_o.direct_access_cycle_lamp;
    end
    if (cpu_i.int_cycle && bus_data_oe_o) id <= bus_data_o;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    {mem_acc_sw_i, io_acc_sw_i, io_in_sw_i, wait_sw_i, srch_wait_sw_i, sense_sw_i} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, cpu_addr_i, cpu_data_i, panel_sw_i} = '0;
    {keys_i, cx} = '0;
    s_axi_wstrb = 4'hf;
    bus_rdata_i = 8'h69;
    srst_i = 1'b1;
    tick(16);
    srst_i <= 1'b0;
    tick(4);
    axr(32'h0000_0000);
    chk(rd, 32'h0000_0080);
    axr(32'h0000_000c);
    chk(rr, 2'h2);
    axw(32'h0000_0008, 32'h0000_0001);
    chk(rr, 2'h0);
    tick(4);
    chk(st_lamp_o.waiting, 1'b1);
    chk(st_lamp_o.run, 1'b0);
    press(0, 16'h0000);
    chk(wait_req_o, 1'b0);
    cx.sync <= 1'b1;
    tick(1);
    cx.sync <= 1'b0;
    tick(3);
    chk(wait_req_o, 1'b1);
    axw(32'h0000_0008, 32'h0000_0000);
    tick(4);
    chk(wait_req_o, 1'b0);
    wait_sw_i <= 1'b1;
    tick(3);
    chk(wait_req_o, 1'b1);
    wait_sw_i <= 1'b0;
    tick(3);
    chk(wait_req_o, 1'b0);
    $display("wait and step test done");
    press(6, 16'h00aa);
    chk(nw, 0);
    mem_acc_sw_i <= 1'b1;
    tick(4);
    chk({hold_req_o, st_lamp_o.hold, st_lamp_o.access_req}, 3'h7);
    press(7, 16'h1234);
    chk({bus_addr_o, data_lamp_o}, {16'h1234, 8'h69});
    chk({cyc_lamp_o.mem, cyc_lamp_o.direct_access_cycle_lamp, cyc_lamp_o.rd_in, bus_mem_rd_o}, 4'hf);
    press(5, 16'h0000);
    press(5, 16'h0000);
    press(4, 16'h0000);
    axr(32'h0000_0004);
    chk(rd[15:0], 16'h1235);
    press(6, 16'hffa5);
    chk(nw, 32'd25);
    chk({wa, wd, 7'h0, da}, {16'h1235, 8'ha5, 8'h01});
    mem_acc_sw_i <= 1'b0;
    io_acc_sw_i  <= 1'b1;
    tick(4);
    press(6, 16'h3c5a);
    chk({wa, wd}, {16'h003c, 8'h5a});
    io_in_sw_i  <= 1'b1;
    bus_rdata_i <= 8'h96;
    press(6, 16'h3c00);
    chk(data_lamp_o, 8'h96);
    io_acc_sw_i <= 1'b0;
    $display("console access test done");
    press(3, 16'h00c7);
    chk({id, int_req_o, st_lamp_o.int_dis}, {8'hc7, 2'b01});
    press(2, 16'h0000);
    chk(st_lamp_o.int_req, 1'b1);
    sense_sw_i <= 1'b1;
    panel_sw_i <= 16'h9e00;
    cx.io_in   <= 1'b1;
    cx.stack   <= 1'b1;
    tick(3);
    chk({bus_data_oe_o, bus_data_o}, 9'h19e);
    chk({cyc_lamp_o.stack, cyc_lamp_o.io, cyc_lamp_o.rd_in}, 3'h7);
    {sense_sw_i, cx.io_in, cx.stack} <= 3'b000;
    cx.io_out  <= 1'b1;
    cpu_addr_i <= 16'h00ff;
    cpu_data_i <= 8'h3c;
    tick(2);
    cx.io_out  <= 1'b0;
    tick(2);
    chk({prog_lamp_o, addr_lamp_o}, 24'h3c00ff);
    srch_wait_sw_i <= 1'b1;
    press(1, 16'h0002);
    press(7, 16'h0040);
    cpu_addr_i <= 16'h0040;
    for (int i = 0; i < 2; i++) begin
      {cx.fetch, cx.sync} <= 2'b11;
      tick(1);
      {cx.fetch, cx.sync} <= 2'b00;
      tick(4);
      chk({st_lamp_o.search_done_lamp, wait_req_o}, {2{i == 1}});
    end
    $display("interrupt sense search test done");
    final_report();
  end
endmodule : tb
